//--- rtl/dmha_pkg.sv
// constants shared by the display memory host port and its host end
// Overview of operation
// - C/D low, R/W high reads status
// - status bits: busy 7, off 5, reset 4
// - busy high while internal operation runs
// - off flag is inverse of display on
// - reset flag high during device reset
// - C/D high, R/W low writes data
// - write stores byte at page and column
// - column increments after data write
// - read drives latch, then reloads it
// - column increments after latch reload
// - host end passes the first, dummy read through unfiltered
// - writes go straight to memory
// - C/D high, R/W high reads data
// - column wraps from 63 to zero
// - eight pages selected by page pointer
package dmha_pkg;
	localparam int DMHA_DATA_W = 8;
	localparam int DMHA_PAGE_W = 3;
	localparam int DMHA_COL_W = 6;
	localparam int DMHA_DEPTH = 512;
	localparam int DMHA_BUSY_BIT = 7;
	localparam int DMHA_OFF_BIT = 5;
	localparam int DMHA_RST_BIT = 4;
	localparam logic [5:0] DMHA_COL_MAX = 6'h3F;
	localparam logic [5:0] DMHA_COL_RESET = 6'h00;
	localparam logic [2:0] DMHA_PAGE_RESET = 3'h0;
	localparam logic [7:0] DMHA_LATCH_RESET = 8'h00;
	localparam logic [7:0] DMHA_STATUS_RESET = 8'h20;
	// control codes on the command bus
	localparam logic [7:0] DMHA_CMD_ON_BASE = 8'h3E;
	localparam logic [7:0] DMHA_CMD_PAGE_BASE = 8'hB8;
	localparam logic [7:0] DMHA_CMD_COL_BASE = 8'h40;
	localparam logic [7:0] DMHA_CMD_START_BASE = 8'hC0;
	// internal timing in clk_sys cycles
	localparam logic [3:0] DMHA_RESET_CYCLES = 4'h8;
	localparam logic [3:0] DMHA_BUSY_CYCLES = 4'h2;
	localparam logic [3:0] DMHA_HOST_HOLD = 4'h3;
	typedef enum logic [2:0] {
		DMHA_H_IDLE = 3'b000,
		DMHA_H_SETUP = 3'b001,
		DMHA_H_STROBE = 3'b010,
		DMHA_H_RELEASE = 3'b011,
		DMHA_H_DONE = 3'b100
	} dmha_host_state_type;
	typedef enum logic [1:0] {
		DMHA_OP_STATUS = 2'b00,
		DMHA_OP_CMD = 2'b01,
		DMHA_OP_WRITE = 2'b10,
		DMHA_OP_READ = 2'b11
	} dmha_op_type;
endpackage

//--- rtl/dmha_bus_if.sv
// parallel host bus between host and display memory device
`timescale 1ns/1ps
interface dmha_bus_if;
	logic cd_sel;
	logic rw_sel;
	logic enable;
	logic [7:0] host_data_lines_host;
	logic host_data_lines_host_oe;
	logic [7:0] host_data_lines_dev;
	logic host_data_lines_dev_oe;
	logic [7:0] host_data_lines;
	// resolved bus level; undriven reads as all ones like a pulled-up bus
	assign host_data_lines = host_data_lines_dev_oe ? host_data_lines_dev :
		(host_data_lines_host_oe ? host_data_lines_host : 8'hFF);
	modport device (
		input cd_sel,
		input rw_sel,
		input enable,
		input host_data_lines,
		output host_data_lines_dev,
		output host_data_lines_dev_oe
	);
	modport host (
		output cd_sel,
		output rw_sel,
		output enable,
		input host_data_lines,
		output host_data_lines_host,
		output host_data_lines_host_oe
	);
endinterface

//--- rtl/dmha_device.sv
// device end: status, pointers, display memory and output latch
`timescale 1ns/1ps
module dmha_device
	import dmha_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// host bus
	dmha_bus_if.device bus,
	// display side
	output logic display_on,
	output logic [5:0] start_line,
	output logic busy,
	output logic in_reset
);
	logic [1:0] cd_sync_reg;
	logic [1:0] rw_sync_reg;
	logic [1:0] en_sync_reg;
	logic [7:0] d_sync1_reg;
	logic [7:0] d_sync2_reg;
	logic en_prev_reg;
	logic [7:0] mem [0:DMHA_DEPTH-1];
	logic [2:0] page_reg;
	logic [5:0] col_reg;
	logic [7:0] latch_reg;
	logic on_reg;
	logic [5:0] start_reg;
	logic [3:0] rst_cnt_reg;
	logic [3:0] busy_cnt_reg;
	logic [7:0] dout_reg;
	logic oe_reg;
	logic rise;
	logic fall;
	logic accept;
	logic [7:0] status;
	logic [8:0] addr;
	logic take_cmd;
	logic take_write;
	logic take_read;
	logic take_data;

	// access kind from the synchronised select lines
	function automatic logic kind_status(input logic cd, input logic rw);
		return !cd && rw;
	endfunction

	function automatic logic kind_cmd(input logic cd, input logic rw);
		return !cd && !rw;
	endfunction

	function automatic logic kind_write(input logic cd, input logic rw);
		return cd && !rw;
	endfunction

	function automatic logic kind_read(input logic cd, input logic rw);
		return cd && rw;
	endfunction

	// command classes; the low bits of each code carry its operand
	function automatic logic code_is_on(input logic [7:0] code);
		return code[7:1] == DMHA_CMD_ON_BASE[7:1];
	endfunction

	function automatic logic code_is_page(input logic [7:0] code);
		return code[7:3] == DMHA_CMD_PAGE_BASE[7:3];
	endfunction

	function automatic logic code_is_col(input logic [7:0] code);
		return code[7:6] == DMHA_CMD_COL_BASE[7:6];
	endfunction

	function automatic logic code_is_start(input logic [7:0] code);
		return code[7:6] == DMHA_CMD_START_BASE[7:6];
	endfunction

	// pins are asynchronous to clk_sys; each passes two flip-flops
	always_ff @(posedge clk_sys) begin
		cd_sync_reg <= {cd_sync_reg[0], bus.cd_sel};
		rw_sync_reg <= {rw_sync_reg[0], bus.rw_sel};
		en_sync_reg <= {en_sync_reg[0], bus.enable};
	end

	// data runs the same two stages as the strobe, so both line up at the fall
	always_ff @(posedge clk_sys) begin
		d_sync1_reg <= bus.host_data_lines;
		d_sync2_reg <= d_sync1_reg;
	end

	// strobe history for edge detection, taken from the second stage only
	always_ff @(posedge clk_sys) begin
		en_prev_reg <= en_sync_reg[1];
	end

	assign rise = en_sync_reg[1] & ~en_prev_reg;
	assign fall = ~en_sync_reg[1] & en_prev_reg;
	// status reads are always served; everything else only when idle
	assign accept = fall & (busy_cnt_reg == 4'h0) & (rst_cnt_reg == 4'h0);
	assign addr = {page_reg, col_reg};
	assign take_cmd = accept & kind_cmd(cd_sync_reg[1], rw_sync_reg[1]);
	assign take_write = accept & kind_write(cd_sync_reg[1], rw_sync_reg[1]);
	assign take_read = accept & kind_read(cd_sync_reg[1], rw_sync_reg[1]);
	assign take_data = take_write | take_read;

	always_comb begin
		status = 8'h00;
		status[DMHA_BUSY_BIT] = (busy_cnt_reg != 4'h0) | (rst_cnt_reg != 4'h0);
		status[DMHA_OFF_BIT] = ~on_reg;
		status[DMHA_RST_BIT] = (rst_cnt_reg != 4'h0);
	end

	// reset sequence counter
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rst_cnt_reg <= DMHA_RESET_CYCLES;
		end else if (rst_cnt_reg != 4'h0) begin
			rst_cnt_reg <= rst_cnt_reg - 4'h1;
		end
	end

	// busy timer after each accepted access other than a status read
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			busy_cnt_reg <= 4'h0;
		end else if (accept && !kind_status(cd_sync_reg[1], rw_sync_reg[1])) begin
			busy_cnt_reg <= DMHA_BUSY_CYCLES;
		end else if (busy_cnt_reg != 4'h0) begin
			busy_cnt_reg <= busy_cnt_reg - 4'h1;
		end
	end

	// bus drive: data or status presented while enable is high on a read
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			oe_reg <= 1'b0;
			dout_reg <= 8'h00;
		end else if (rise && rw_sync_reg[1]) begin
			oe_reg <= 1'b1;
			dout_reg <= cd_sync_reg[1] ? latch_reg : status;
		end else if (fall) begin
			oe_reg <= 1'b0;
		end
	end

	// display on/off register; the display stays off out of reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			on_reg <= 1'b0;
		end else if (take_cmd && code_is_on(d_sync2_reg)) begin
			on_reg <= d_sync2_reg[0];
		end
	end

	// start line register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			start_reg <= 6'h00;
		end else if (take_cmd && code_is_start(d_sync2_reg)) begin
			start_reg <= d_sync2_reg[5:0];
		end
	end

	// page pointer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			page_reg <= DMHA_PAGE_RESET;
		end else if (take_cmd && code_is_page(d_sync2_reg)) begin
			page_reg <= d_sync2_reg[2:0];
		end
	end

	// column pointer: load by command, auto-increment after data access
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			col_reg <= DMHA_COL_RESET;
		end else if (take_cmd && code_is_col(d_sync2_reg)) begin
			col_reg <= d_sync2_reg[5:0];
		end else if (take_data) begin
			// the pointer moves only once the access itself is done
			col_reg <= (col_reg == DMHA_COL_MAX) ? 6'h00 : col_reg + 6'h01;
		end
	end

	// memory write goes straight in; no dummy write is needed
	always_ff @(posedge clk_sys) begin
		if (take_write) begin
			mem[addr] <= d_sync2_reg;
		end
	end

	// latch reload after the old latch value was driven
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			latch_reg <= DMHA_LATCH_RESET;
		end else if (take_read) begin
			latch_reg <= mem[addr];
		end
	end

	// outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			display_on <= 1'b0;
			start_line <= 6'h00;
			busy <= 1'b1;
			in_reset <= 1'b1;
		end else begin
			display_on <= on_reg;
			start_line <= start_reg;
			busy <= status[DMHA_BUSY_BIT];
			in_reset <= status[DMHA_RST_BIT];
		end
	end

	assign bus.host_data_lines_dev = dout_reg;
	assign bus.host_data_lines_dev_oe = oe_reg;
endmodule

//--- rtl/dmha_host.sv
// host end: one bus cycle per request, optional busy polling first
`timescale 1ns/1ps
module dmha_host
	import dmha_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// host bus
	dmha_bus_if.host bus,
	// user request
	input wire logic req_valid,
	input wire logic [1:0] req_op,
	input wire logic [7:0] req_data,
	output logic req_ready,
	// user answer
	output logic rsp_valid,
	output logic [7:0] rsp_data
);
	dmha_host_state_type state_reg;
	logic [1:0] op_reg;
	logic [7:0] wdata_reg;
	logic [3:0] hold_reg;
	logic poll_reg;
	logic [7:0] d_sync1_reg;
	logic [7:0] d_sync2_reg;
	logic cd_reg;
	logic rw_reg;
	logic en_reg;
	logic oe_reg;

	always_ff @(posedge clk_sys) begin
		d_sync1_reg <= bus.host_data_lines;
		d_sync2_reg <= d_sync1_reg;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= DMHA_H_IDLE;
			op_reg <= 2'b00;
			wdata_reg <= 8'h00;
			hold_reg <= 4'h0;
			poll_reg <= 1'b0;
			cd_reg <= 1'b0;
			rw_reg <= 1'b1;
			en_reg <= 1'b0;
			oe_reg <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
		end else begin
			rsp_valid <= 1'b0;
			unique case (state_reg)
				DMHA_H_IDLE: begin
					req_ready <= 1'b1;
					if (req_valid && req_ready) begin
						req_ready <= 1'b0;
						op_reg <= req_op;
						wdata_reg <= req_data;
						// poll status before any non-status access
						poll_reg <= (req_op != DMHA_OP_STATUS);
						state_reg <= DMHA_H_SETUP;
					end
				end
				DMHA_H_SETUP: begin
					cd_reg <= poll_reg ? 1'b0 : op_reg[1];
					rw_reg <= poll_reg ? 1'b1 : (op_reg == DMHA_OP_STATUS || op_reg == DMHA_OP_READ);
					oe_reg <= !poll_reg && (op_reg == DMHA_OP_CMD || op_reg == DMHA_OP_WRITE);
					hold_reg <= DMHA_HOST_HOLD;
					state_reg <= DMHA_H_STROBE;
				end
				DMHA_H_STROBE: begin
					en_reg <= 1'b1;
					if (hold_reg != 4'h0) begin
						hold_reg <= hold_reg - 4'h1;
					end else begin
						state_reg <= DMHA_H_RELEASE;
					end
				end
				DMHA_H_RELEASE: begin
					en_reg <= 1'b0;
					hold_reg <= DMHA_HOST_HOLD;
					state_reg <= DMHA_H_DONE;
				end
				DMHA_H_DONE: begin
					oe_reg <= 1'b0;
					if (hold_reg != 4'h0) begin
						hold_reg <= hold_reg - 4'h1;
					end else if (poll_reg) begin
						// busy seen: poll again, else perform the access
						poll_reg <= d_sync2_reg[DMHA_BUSY_BIT];
						state_reg <= DMHA_H_SETUP;
					end else begin
						// read data answer is the prior latch content, see dummy read
						rsp_valid <= 1'b1;
						rsp_data <= d_sync2_reg;
						rw_reg <= 1'b1;
						state_reg <= DMHA_H_IDLE;
					end
				end
				default: begin
					state_reg <= DMHA_H_IDLE;
				end
			endcase
		end
	end

	assign bus.cd_sel = cd_reg;
	assign bus.rw_sel = rw_reg;
	assign bus.enable = en_reg;
	assign bus.host_data_lines_host = wdata_reg;
	assign bus.host_data_lines_host_oe = oe_reg;
endmodule

//--- verif/dmha_sva.sv
// assertions on the host bus between host end and device end
`timescale 1ns/1ps
module dmha_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// host bus
	input wire logic cd_sel,
	input wire logic rw_sel,
	input wire logic enable,
	input wire logic [7:0] host_data_lines_dev,
	input wire logic host_data_lines_dev_oe,
	input wire logic host_data_lines_host_oe
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_strobe_on;
		$rose(enable);
	endsequence
	sequence s_status_strobe;
		s_strobe_on ##0 (!cd_sel && rw_sel);
	endsequence
	a_no_bus_fight:
	assert property (!(host_data_lines_dev_oe && host_data_lines_host_oe))
		else $error("both ends drive the data lines");
	a_host_drives_write:
	assert property (host_data_lines_host_oe |-> !rw_sel)
		else $error("host drives data lines on a read");
	a_dev_drives_read:
	assert property ($rose(host_data_lines_dev_oe) |-> enable && rw_sel)
		else $error("device drives outside a read strobe");
	a_status_zero_bits:
	assert property ($rose(host_data_lines_dev_oe) && !cd_sel |=>
		host_data_lines_dev[6] == 1'b0 && host_data_lines_dev[3:0] == 4'h0)
		else $error("status fixed bits not zero");
	a_status_answered:
	assert property (s_status_strobe |-> ##[1:6] host_data_lines_dev_oe)
		else $error("status read not answered");
	a_bus_released:
	assert property ($fell(enable) |-> ##[1:6] !host_data_lines_dev_oe)
		else $error("device keeps data lines after strobe");
	a_strobe_width:
	assert property (s_strobe_on |-> enable [*3])
		else $error("strobe too short");
	a_select_steady:
	assert property (enable && $past(enable) |-> $stable(cd_sel) && $stable(rw_sel))
		else $error("select lines move during strobe");
endmodule

//--- verif/test_display_memory_host_access.sv
// self-checking bench: host end driving device end over the bus
`timescale 1ns/1ps
module test_display_memory_host_access;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic [1:0] req_op = 2'h0;
	logic [7:0] req_data = 8'h00;
	logic req_ready;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic display_on;
	logic [5:0] start_line;
	logic busy;
	logic in_reset;
	logic [7:0] a, b, c;
	logic [2:0] p;
	logic [8:0] note;
	logic [8:0] exp_q[$];
	int err_count = 0;
	int n_compared = 0;
	always #20 clk_sys = ~clk_sys;
	dmha_bus_if i_dmha_bus_if();
	dmha_device i_dmha_device(.clk_sys(clk_sys), .rst_n(rst_n), .bus(i_dmha_bus_if),
		.display_on(display_on), .start_line(start_line), .busy(busy), .in_reset(in_reset));
	dmha_host i_dmha_host(.clk_sys(clk_sys), .rst_n(rst_n), .bus(i_dmha_bus_if),
		.req_valid(req_valid), .req_op(req_op), .req_data(req_data), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	dmha_sva i_dmha_sva(.clk_sys(clk_sys), .rst_n(rst_n), .cd_sel(i_dmha_bus_if.cd_sel),
		.rw_sel(i_dmha_bus_if.rw_sel), .enable(i_dmha_bus_if.enable),
		.host_data_lines_dev(i_dmha_bus_if.host_data_lines_dev),
		.host_data_lines_dev_oe(i_dmha_bus_if.host_data_lines_dev_oe),
		.host_data_lines_host_oe(i_dmha_bus_if.host_data_lines_host_oe));
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_compared++;
		if (seen !== want) begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// note bit 8 set means the answer is compared, clear means it is only counted off
	task automatic op(input logic [1:0] o, input logic [7:0] d, input logic [8:0] e);
		int n;
		exp_q.push_back(e);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_op <= o;
		req_data <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 500);
		if (n >= 500) begin
			err_count++;
			wrap_up();
		end
		req_valid <= 1'b0;
	endtask
	always @(posedge clk_sys) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("ERROR at %0t: seen %h expected %h", $time, rsp_data, 8'h00);
			end else begin
				note = exp_q.pop_front();
				if (note[8])
					check(rsp_data, note[7:0]);
			end
		end
	end
	initial begin
		void'($urandom(43));
		{p, a, b, c} = 27'($urandom);
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		// issued at once: the host must poll through the reset busy time
		op(2'h1, {2'b11, c[5:0]}, 9'h000);
		check({6'h00, busy, in_reset}, 8'h03);
		// the reset flag runs 8 cycles after release
		repeat (10) @(posedge clk_sys);
		op(2'h0, 8'h00, 9'h120);
		op(2'h1, 8'h3F, 9'h000);
		op(2'h0, 8'h00, 9'h100);
		check({7'h00, display_on}, 8'h01);
		op(2'h1, {5'b10111, p}, 9'h000);
		op(2'h1, 8'h7F, 9'h000);
		op(2'h2, a, 9'h000);
		op(2'h2, b, 9'h000);
		op(2'h1, 8'h7F, 9'h000);
		op(2'h3, 8'h00, 9'h100);
		op(2'h3, 8'h00, {1'b1, a});
		op(2'h3, 8'h00, {1'b1, b});
		op(2'h1, {5'b10111, p + 3'h1}, 9'h000);
		op(2'h1, 8'h40, 9'h000);
		op(2'h2, c, 9'h000);
		op(2'h1, {5'b10111, p}, 9'h000);
		op(2'h1, 8'h40, 9'h000);
		op(2'h3, 8'h00, 9'h000);
		op(2'h3, 8'h00, {1'b1, b});
		op(2'h1, {5'b10111, p + 3'h1}, 9'h000);
		op(2'h1, 8'h40, 9'h000);
		op(2'h3, 8'h00, 9'h000);
		op(2'h3, 8'h00, {1'b1, c});
		op(2'h1, 8'h3E, 9'h000);
		op(2'h0, 8'h00, 9'h120);
		for (int i = 0; i < 300 && exp_q.size() > 0; i++)
			@(posedge clk_sys);
		check({7'h00, display_on}, 8'h00);
		check({2'b00, start_line}, {2'b00, c[5:0]});
		check({6'h00, busy, in_reset}, 8'h00);
		if (exp_q.size() > 0)
			err_count++;
		wrap_up();
	end
endmodule
